// *** rtl/iarp_top.v ***
/*
  Indirect register access port behind an SPI slave (mode 0, MSB first).
  Holds the direct register space, the indirect pointer and the indirect space.
  Assumes: spi pins arrive asynchronously, sclk at most clk/8; power state
  bits and soft_reset come from logic on clk.

//////////////////////////////////////////////////////////////////////////////
*/
`timescale 1ns/1ns
`include "iarp_defines.vh"

module iarp_top #(
  parameter [7:0] PART_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // spi pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  // power state and soft reset
  input wire oscillator_enable,
  input wire power_controller_level,
  input wire soft_reset,
  // status
  output reg hibernate,
  output reg [7:0] indirect_pointer
);

  localparam [2:0] ST_CMD = 3'h0;
  localparam [2:0] ST_DIR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_IND = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // read-only indirect targets
  function ind_writable;
    input [7:0] a;
    begin
      ind_writable = (a != `IARP_IND_PART_ID) && (a != `IARP_IND_PAN_STATUS);
    end
  endfunction

  // value seen through the window
  function [7:0] ind_view;
    input [7:0] a;
    input [7:0] m;
    begin
      if (a == `IARP_IND_PART_ID)
        ind_view = PART_ID;
      else if (a == `IARP_IND_PAN_STATUS)
        ind_view = `IARP_STATUS_VALUE;
      else
        ind_view = m;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  wire [2:0] pins_s;
  wire sclk_s = pins_s[2];
  wire cs_n_s = pins_s[1];
  wire mosi_s = pins_s[0];

  iarp_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .clk(clk),
    .reset(reset),
    .lvl_raw({spi_sclk, spi_cs_n, spi_mosi}),
    .lvl_sync(pins_s)
  );

  reg sclk_prev_q;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [6:0] sh_q;
  reg rw_q;
  reg [5:0] addr_q;
  reg [7:0] tx_q;

  wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  wire byte_done = sclk_rise && (bit_q == 3'h7);
  wire [7:0] rx_byte = {sh_q, mosi_s};
  wire hib = ~oscillator_enable & ~power_controller_level;

  //////////////////////////////////////////////////////////////////////////////
  // storage

  reg [7:0] dir_mem [0:`IARP_DIR_DEPTH-1];
  reg [7:0] ind_mem [0:`IARP_IND_DEPTH-1];
  integer i;

  wire [5:0] addr_inc = addr_q + 6'h01;
  wire [7:0] ptr_inc = indirect_pointer + 8'h01;
  wire [5:0] dir_ra = (state_q == ST_CMD) ? rx_byte[`IARP_CW_ADDR_MSB:0] : addr_inc;
  wire [7:0] ind_ra = (state_q == ST_PTR) ? rx_byte :
                      (state_q == ST_IND) ? ptr_inc : indirect_pointer;
  wire [7:0] ind_rdata = ind_view(ind_ra, ind_mem[ind_ra]);
  wire [7:0] dir_rdata = (dir_ra == `IARP_ADDR_PTR) ? indirect_pointer :
                         (dir_ra == `IARP_ADDR_WIN) ? ind_rdata : dir_mem[dir_ra];

  //////////////////////////////////////////////////////////////////////////////
  // byte decode

  reg [2:0] state_d;
  reg [5:0] addr_d;
  reg [7:0] ptr_d;
  reg rw_d;
  reg [7:0] tx_d;
  reg dir_we;
  reg ind_we;

  always @* begin
    state_d = state_q;
    addr_d = addr_q;
    ptr_d = indirect_pointer;
    rw_d = rw_q;
    tx_d = 8'h00;
    dir_we = 1'b0;
    ind_we = 1'b0;
    case (state_q)
      ST_CMD: begin
        rw_d = rx_byte[`IARP_CW_READ_BIT];
        addr_d = rx_byte[`IARP_CW_ADDR_MSB:0];
        if (addr_d == `IARP_ADDR_PTR) begin
          state_d = ST_PTR;
          tx_d = indirect_pointer;
        end else if (addr_d == `IARP_ADDR_WIN) begin
          state_d = ST_IND;
          tx_d = ind_rdata;
        end else begin
          state_d = ST_DIR;
          tx_d = dir_rdata;
        end
      end
      ST_PTR: begin
        ptr_d = rx_byte;
        state_d = ST_IND;
        tx_d = ind_rdata;
      end
      ST_IND: begin
        ind_we = ~rw_q & ind_writable(indirect_pointer);
        if (hib) begin
          state_d = ST_SKIP;
        end else begin
          ptr_d = ptr_inc;
          tx_d = ind_rdata;
        end
      end
      ST_DIR: begin
        if (~rw_q) begin
          if (addr_q == `IARP_ADDR_PTR)
            ptr_d = rx_byte;
          else if (addr_q == `IARP_ADDR_WIN)
            ind_we = ind_writable(indirect_pointer);
          else
            dir_we = 1'b1;
        end
        addr_d = addr_inc;
        tx_d = dir_rdata;
      end
      ST_SKIP: begin
        state_d = ST_SKIP;
      end
      default: begin
        state_d = ST_CMD;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // spi framing and pointer

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      state_q <= ST_CMD;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      rw_q <= 1'b0;
      addr_q <= 6'h00;
      tx_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      hibernate <= 1'b0;
      indirect_pointer <= `IARP_PTR_RESET;
    end else begin
      sclk_prev_q <= sclk_s;
      spi_miso_oe <= ~cs_n_s;
      hibernate <= hib;
      // soft_reset is deliberately not looked at here
      if (cs_n_s) begin
        state_q <= ST_CMD;
        bit_q <= 3'h0;
      end else begin
        if (sclk_rise) begin
          sh_q <= rx_byte[6:0];
          bit_q <= bit_q + 3'h1;
        end
        if (sclk_fall) begin
          spi_miso <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
        if (byte_done) begin
          state_q <= state_d;
          addr_q <= addr_d;
          rw_q <= rw_d;
          tx_q <= tx_d;
          indirect_pointer <= ptr_d;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register arrays

  always @(posedge clk) begin
    if (soft_reset) begin
      for (i = 0; i < `IARP_DIR_DEPTH; i = i + 1)
        dir_mem[i[5:0]] <= `IARP_DIR_RESET;
    end else if (byte_done && ~cs_n_s && dir_we) begin
      dir_mem[addr_q] <= rx_byte;
    end
    if (byte_done && ~cs_n_s && ind_we)
      ind_mem[indirect_pointer] <= rx_byte;
  end

endmodule // iarp_top

// *** inc/iarp_defines.vh ***
/*
  Constants of the indirect register access port: direct map positions,
  control word fields, indirect map positions and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef IARP_DEFINES_VH
`define IARP_DEFINES_VH

// direct map
`define IARP_ADDR_W 6
`define IARP_ADDR_PTR 6'h3E
`define IARP_ADDR_WIN 6'h3F
`define IARP_DIR_DEPTH 64

// control word fields
`define IARP_CW_READ_BIT 7
`define IARP_CW_ADDR_MSB 5

// indirect map
`define IARP_IND_DEPTH 256
`define IARP_IND_PART_ID 8'h00
`define IARP_IND_PAN_STATUS 8'h21

// reset values
`define IARP_PTR_RESET 8'h00
`define IARP_DIR_RESET 8'h00
`define IARP_STATUS_VALUE 8'h00

`endif

// *** rtl/iarp_sync.v ***
/*
  Two-flop synchroniser for a group of independent pin levels.
  Assumes each bit changes slowly compared with clk; no bus coherency.
*/
`timescale 1ns/1ns

module iarp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // levels
  input wire [W-1:0] lvl_raw,
  output reg [W-1:0] lvl_sync
);

  reg [W-1:0] meta_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= RST_VAL;
      lvl_sync <= RST_VAL;
    end else begin
      meta_q <= lvl_raw;
      lvl_sync <= meta_q;
    end
  end

endmodule // iarp_sync

// *** verification/iarp_monitor.sv ***
/* Checker on the indirect access port pins.
   Assumes one clk domain and the bind at the foot. */
`timescale 1ns/1ns
module iarp_monitor (
  // clock and reset
  input wire clk,
  input wire reset,
  // pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_miso,
  input wire spi_miso_oe,
  input wire oscillator_enable,
  input wire power_controller_level,
  input wire hibernate,
  input wire [7:0] indirect_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence idle_s; spi_cs_n [*6]; endsequence
  sequence sel_s; !spi_cs_n [*5]; endsequence
  a_hib_on: assert property (!oscillator_enable && !power_controller_level |=> hibernate)
    else $error("hibernate missing");
  a_hib_off: assert property (oscillator_enable || power_controller_level |=> !hibernate)
    else $error("hibernate stray");
  a_ptr_hold: assert property (idle_s |=> $stable(indirect_pointer))
    else $error("pointer moved while idle");
  a_ptr_move: assert property ($changed(indirect_pointer) |-> $past(spi_sclk, 2)
    || $past(spi_sclk, 3) || $past(spi_sclk, 4) || $past(spi_sclk, 5))
    else $error("pointer moved off a byte end");
  a_oe_on: assert property (sel_s |-> spi_miso_oe)
    else $error("oe low while selected");
  a_oe_off: assert property (idle_s |-> !spi_miso_oe)
    else $error("oe high while idle");
  a_miso_idle: assert property (idle_s |=> $stable(spi_miso))
    else $error("miso moved while idle");
  a_miso_fall: assert property ($changed(spi_miso) |-> !spi_sclk && !spi_cs_n)
    else $error("miso moved off sclk low");
endmodule // iarp_monitor

bind iarp_top iarp_monitor iarp_monitor_inst (.*);

// *** verification/iarp_spi_host.sv ***
/* Host model: spi master, mode 0, msb first, sclk 8 clk.
   Assumes the caller runs one frame at a time. */
`timescale 1ns/1ns
module iarp_spi_host (
  // clock
  input wire clk,
  // pins
  output reg spi_sclk = 1'b0,
  output reg spi_cs_n = 1'b1,
  output reg spi_mosi = 1'b0,
  input wire spi_miso
);
  task sel(input logic on);
    repeat (4) @(negedge clk);
    spi_cs_n = !on;
    // released line must not keep its last bit
    if (!on) spi_mosi = !spi_mosi;
    repeat (4) @(negedge clk);
  endtask
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (4) @(negedge clk);
      rx[i] = spi_miso;
      spi_sclk = 1'b1;
      repeat (4) @(negedge clk);
      spi_sclk = 1'b0;
    end
  endtask
endmodule // iarp_spi_host

// *** verification/iarp_top_tb.sv ***
/* Bench for the indirect access port, driving frames through the host model.
   Assumes the monitor is bound to the design. */
`timescale 1ns/1ns
module iarp_top_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic oscillator_enable = 1'b1;
  logic power_controller_level = 1'b1;
  logic soft_reset = 1'b0;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, hibernate;
  wire [7:0] indirect_pointer;
  logic [7:0] tx [0:3];
  logic [7:0] rx [0:3];
  int n_fail = 0;
  int compares = 0;
  always #20 clk = ~clk;
  iarp_top #(.PART_ID(8'hC3)) iarp_top_inst (.*);
  iarp_spi_host iarp_spi_host_inst (.*);
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task frame(input logic [7:0] a, b, c, d, input int n);
    integer i;
    tx = '{a, b, c, d};
    iarp_spi_host_inst.sel(1'b1);
    for (i = 0; i < n; i++) iarp_spi_host_inst.xbyte(tx[i], rx[i]);
    iarp_spi_host_inst.sel(1'b0);
  endtask
  task t_burst;
    frame(8'h3E, 8'h10, 8'hAB, 8'hCD, 4);
    check(indirect_pointer, 8'h12);
    frame(8'hBE, 8'h10, 8'h00, 8'h00, 4);
    check(rx[1], 8'h12);
    check(rx[2], 8'hAB);
    check(rx[3], 8'hCD);
    $display("burst done");
  endtask
  task t_window;
    frame(8'h3E, 8'hFF, 8'h00, 8'h00, 2);
    frame(8'h3F, 8'h11, 8'h22, 8'h00, 3);
    check(indirect_pointer, 8'h01);
    frame(8'h3E, 8'hFF, 8'h00, 8'h00, 2);
    frame(8'hBF, 8'h00, 8'h00, 8'h00, 3);
    check(rx[1], 8'h11);
    check(rx[2], 8'hC3);
    frame(8'h3D, 8'h5C, 8'h40, 8'h99, 4);
    check(rx[2], 8'h01);
    check(indirect_pointer, 8'h40);
    frame(8'hBF, 8'h00, 8'h00, 8'h00, 2);
    check(rx[1], 8'h99);
    $display("window done");
  endtask
  task t_hib;
    frame(8'h3E, 8'h30, 8'h66, 8'h55, 4);
    oscillator_enable = 1'b0;
    power_controller_level = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, hibernate}, 8'h01);
    frame(8'h3E, 8'h30, 8'h77, 8'h88, 4);
    check(indirect_pointer, 8'h30);
    frame(8'hBE, 8'h30, 8'h00, 8'h00, 3);
    check(rx[2], 8'h77);
    check(indirect_pointer, 8'h30);
    frame(8'h05, 8'hA1, 8'hA2, 8'h00, 3);
    frame(8'h85, 8'h00, 8'h00, 8'h00, 3);
    check(rx[1], 8'hA1);
    check(rx[2], 8'hA2);
    oscillator_enable = 1'b1;
    repeat (2) @(negedge clk);
    check({7'h00, hibernate}, 8'h00);
    frame(8'hBE, 8'h30, 8'h00, 8'h00, 4);
    check(rx[2], 8'h77);
    check(rx[3], 8'h55);
    $display("hibernate done");
  endtask
  task t_soft;
    soft_reset = 1'b1;
    repeat (3) @(negedge clk);
    soft_reset = 1'b0;
    check(indirect_pointer, 8'h32);
    frame(8'h85, 8'h00, 8'h00, 8'h00, 2);
    check(rx[1], 8'h00);
    $display("soft reset done");
  endtask
  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_burst;
    t_window;
    t_hib;
    t_soft;
    report_and_stop;
  end
  initial begin
    #2000000;
    n_fail++;
    report_and_stop;
  end
endmodule // iarp_top_tb
